/* File: hdl/ipa_consts.svh */
/*
 constants of the indirect parameter access block: addresses, error codes,
 identity widths, self-test timing.
 assumes it is included by bare name from the block's design files.
*/
// Behaviour
// (R1) 22-bit instance identifier from two settings
// (R2) new identifier active only after power-up
// (R3) 20-character device name, network writable
// (R4) written name reported only after power-up
// (R5) controller writes index, then reads value
// (R6) value writes stay pending until commit
// (R7) accept command moves pending into RAM
// (R8) save command commits and stores non-volatile
// (R9) other objects take effect without commit
// (R10) setting selects whether commit is required
// (R11) commit registers write-only, objects readable
// (R12) controller keeps save commands infrequent
// (R13) write during non-volatile save gets busy; code gives busy only to value and commit writes
// (R14) invalid read register gets read-denied
// (R15) out-of-range value gets range error
// (R16) invalid register or blocked mode: write-denied
// (R17) loopback self-test when input six selected
// (R18) show pass, or communication error on fault
// (R19) index retains last written register number
`ifndef IPA_CONSTS_SVH
`define IPA_CONSTS_SVH

`define IPA_INST_HIGH_BITS 6
`define IPA_INST_LOW_BITS 16
`define IPA_INST_ID_BITS 22
`define IPA_NAME_BITS 160
`define IPA_ADDR_SAVE 16'h0900
`define IPA_ADDR_ACCEPT 16'h0910
`define IPA_COMMIT_VALUE 16'h0000
`define IPA_ERR_NONE 8'h00
`define IPA_ERR_BAD_ADDR 8'h02
`define IPA_ERR_BUSY 8'h03
`define IPA_ERR_READ_DENIED 8'h1B
`define IPA_ERR_RANGE 8'h25
`define IPA_ERR_WRITE_DENIED 8'h28
`define IPA_TEST_SELECT 8'h43
`define IPA_PARAM_COUNT 64
`define IPA_VALUE_LIMIT 16'h7FFF
`define IPA_CLOCK_HZ 20000000
`define IPA_TEST_BAUD 9600
`define IPA_TEST_BIT_CYCLES (`IPA_CLOCK_HZ / `IPA_TEST_BAUD)

`endif

/* File: hdl/ipa_pkg.sv */
/*
 types of the indirect parameter access block: request kinds, save states.
 assumes nothing of its surroundings.
*/
package ipa_pkg;

    // which network object or register a request addresses
    typedef enum logic [5:0] {
        KIND_INDEX = 6'b000001,
        KIND_VALUE = 6'b000010,
        KIND_ACCEPT = 6'b000100,
        KIND_SAVE = 6'b001000,
        KIND_OTHER = 6'b010000,
        KIND_REG = 6'b100000
    } ipa_kind_e;

    // non-volatile save walker
    typedef enum logic [2:0] {
        SV_IDLE = 3'b001,
        SV_SCAN = 3'b010,
        SV_WRITE = 3'b100
    } ipa_save_e;

endpackage : ipa_pkg

/* File: hdl/ipa_pin_sync.sv */
/*
 three-flop synchroniser with agreement filter for pin inputs.
 assumes asynchronous pins and the block clock.
*/
`timescale 1ns/1ps
module ipa_pin_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // pins and filtered levels
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] pinOut_next;

    // a bit changes once the second and third flops agree
    genvar b;
    generate
        for (b = 0; b < WIDTH; b++)
        begin : g_bit
            assign pinOut_next[b] = (stage2_reg[b] == stage3_reg[b]) ? stage3_reg[b] : pinOut[b];
        end
    endgenerate

    // shift chain
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
            pinOut <= '0;
        end
        else
        begin
            stage1_reg <= pinIn;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            pinOut <= pinOut_next;
        end
    end
endmodule : ipa_pin_sync

/* File: hdl/ipa_loop_test.sv */
/*
 serial loopback self-test: sends a pseudo-random bit stream and checks it
 comes back. assumes rxLine is already synchronised to clock.
*/
`timescale 1ns/1ps
module ipa_loop_test #(
    parameter int BIT_CYCLES = 2083
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // control and link
    input wire logic enable,
    input wire logic rxLine,
    output logic txLine,
    // display indications
    output logic testPass,
    output logic testFail
);
    logic [15:0] bitCnt_reg;
    logic [6:0] lfsr_reg;
    logic checked_reg;
    wire bitEnd = (bitCnt_reg == 16'(BIT_CYCLES - 1));
    wire mismatch = bitEnd & (rxLine != txLine);
    wire [6:0] lfsrNext = {lfsr_reg[5:0], lfsr_reg[6] ^ lfsr_reg[5]};

    // bit timer, pattern and sticky fault
    always_ff @(posedge clock)
    begin
        if (srst | ~enable)
        begin
            bitCnt_reg <= 16'h0000;
            lfsr_reg <= 7'h01;
            txLine <= 1'b1;
            checked_reg <= 1'b0;
            testPass <= 1'b0;
            testFail <= 1'b0;
        end
        else
        begin
            bitCnt_reg <= bitEnd ? 16'h0000 : bitCnt_reg + 16'h0001;
            if (bitEnd)
            begin
                lfsr_reg <= lfsrNext;
                txLine <= lfsrNext[0];
                checked_reg <= 1'b1;
            end
            testFail <= testFail | mismatch; // R18
            testPass <= checked_reg & ~testFail & ~mismatch; // R18
        end
    end
endmodule : ipa_loop_test

/* File: hdl/ipa_param_access.sv */
/*
 network-side parameter access: identity caught at power-up, index and
 value objects with staging, accept and save commits, error codes,
 loopback self-test. assumes one request at a time
 and that the store acks each write with nvmAck.
*/
`timescale 1ns/1ps
`include "ipa_consts.svh"
module ipa_param_access #(
    parameter int PARAM_COUNT = `IPA_PARAM_COUNT,
    parameter logic [15:0] VALUE_LIMIT = `IPA_VALUE_LIMIT,
    parameter int TEST_BIT_CYCLES = `IPA_TEST_BIT_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // object and register requests
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire ipa_pkg::ipa_kind_e reqKind,
    input wire logic [15:0] reqAddr,
    input wire logic [15:0] reqData,
    // answers
    output logic rspValid,
    output logic [15:0] rspData,
    output logic [7:0] rspErr,
    // writes to other objects
    output logic directWrite,
    output logic [15:0] directAddr,
    output logic [15:0] directData,
    // configuration and drive state
    input wire logic [`IPA_INST_HIGH_BITS-1:0] instanceIdParamHigh,
    input wire logic [`IPA_INST_LOW_BITS-1:0] instanceIdParamLow,
    input wire logic commitRequiredSelect,
    input wire logic [7:0] inputSixFunctionSelect,
    input wire logic autoTuneActive,
    input wire logic busUndervoltageFault,
    // device identity
    output logic [`IPA_INST_ID_BITS-1:0] instanceId,
    input wire logic nameWrite,
    input wire logic [`IPA_NAME_BITS-1:0] nameData,
    input wire logic [`IPA_NAME_BITS-1:0] nameBoot,
    output logic [`IPA_NAME_BITS-1:0] storedName,
    output logic nameStoreStrobe,
    output logic [`IPA_NAME_BITS-1:0] reportedName,
    // non-volatile store
    output logic nvmWrEn,
    output logic [15:0] nvmAddr,
    output logic [15:0] nvmData,
    input wire logic nvmAck,
    output logic saving,
    // serial link and self-test pins
    input wire logic rxPin,
    input wire logic digitalInputSix,
    output logic txLine,
    output logic displayPass,
    output logic displayCommError
);
    localparam int AW = (PARAM_COUNT > 1) ? $clog2(PARAM_COUNT) : 1;
    localparam logic [AW-1:0] LAST = AW'(PARAM_COUNT - 1);

    logic [15:0] index_reg;
    logic booted_reg;
    logic testArmed_reg;
    logic [AW-1:0] ptr_reg;
    ipa_pkg::ipa_save_e state_reg;
    ipa_pkg::ipa_save_e state_next;
    logic [15:0] activeVec [PARAM_COUNT];
    logic [PARAM_COUNT-1:0] pendingVec;
    logic [PARAM_COUNT-1:0] saveMaskVec;
    logic [1:0] pinsSync;
    logic testTx;
    logic testPass;
    logic testFail;
    logic [15:0] rspData_next;
    logic [7:0] rspErr_next;

    // request decode
    wire isWr = reqValid & reqWrite;
    wire isRd = reqValid & ~reqWrite;
    wire kIndex = (reqKind == ipa_pkg::KIND_INDEX);
    wire kValue = (reqKind == ipa_pkg::KIND_VALUE);
    wire kAccept = (reqKind == ipa_pkg::KIND_ACCEPT);
    wire kSave = (reqKind == ipa_pkg::KIND_SAVE);
    wire kOther = (reqKind == ipa_pkg::KIND_OTHER);
    wire kReg = (reqKind == ipa_pkg::KIND_REG);
    wire regAccept = (reqAddr == `IPA_ADDR_ACCEPT);
    wire regSave = (reqAddr == `IPA_ADDR_SAVE);
    wire regCommitVal = (reqData == `IPA_COMMIT_VALUE);
    wire [AW-1:0] entrySel = index_reg[AW-1:0];
    wire indexValid = (index_reg < 16'(PARAM_COUNT));
    wire writeBlocked = autoTuneActive | busUndervoltageFault;
    wire savingNow = (state_reg != ipa_pkg::SV_IDLE);

    // value object write checks in priority order
    wire [7:0] valueWrErr = savingNow ? `IPA_ERR_BUSY : // R13
        (~indexValid | writeBlocked) ? `IPA_ERR_WRITE_DENIED : // R16
        (reqData > VALUE_LIMIT) ? `IPA_ERR_RANGE : // R15
        `IPA_ERR_NONE;
    wire valueWrOk = isWr & kValue & (valueWrErr == `IPA_ERR_NONE);
    wire [7:0] valueRdErr = indexValid ? `IPA_ERR_NONE : `IPA_ERR_READ_DENIED; // R14
    wire [15:0] valueRdData = indexValid ? activeVec[entrySel] : 16'h0000;

    // commit commands from the objects or from the write-only registers
    wire acceptReq = isWr & ((kAccept & reqData[0]) | (kReg & regAccept & regCommitVal)); // R7
    wire saveReq = isWr & ((kSave & reqData[0]) | (kReg & regSave & regCommitVal)); // R8
    wire acceptOk = acceptReq & ~savingNow; // R13
    wire saveOk = saveReq & ~savingNow; // R13
    wire commitNow = acceptOk | saveOk;
    wire regBad = kReg & (~isWr | ~(regAccept | regSave) | ~regCommitVal); // R11
    wire commitBusy = (acceptReq | saveReq) & savingNow;
    wire directNext = isWr & kOther; // R9

    // answer selection
    always_comb
    begin
        rspData_next = 16'h0000;
        rspErr_next = `IPA_ERR_NONE;
        if (kIndex)
        begin
            rspData_next = index_reg;
        end
        else if (kValue)
        begin
            rspData_next = isRd ? valueRdData : 16'h0000;
            rspErr_next = isRd ? valueRdErr : valueWrErr;
        end
        else if (regBad)
        begin
            rspErr_next = `IPA_ERR_BAD_ADDR; // R11
        end
        else if (commitBusy)
        begin
            rspErr_next = `IPA_ERR_BUSY; // R13
        end
        else
        begin
            rspData_next = 16'h0000; // R11
        end
    end

    // answer and direct-write outputs
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            rspValid <= 1'b0;
            rspData <= 16'h0000;
            rspErr <= `IPA_ERR_NONE;
            directWrite <= 1'b0;
            directAddr <= 16'h0000;
            directData <= 16'h0000;
        end
        else
        begin
            rspValid <= reqValid;
            rspData <= reqValid ? rspData_next : 16'h0000;
            rspErr <= reqValid ? rspErr_next : `IPA_ERR_NONE;
            directWrite <= directNext; // R9
            directAddr <= directNext ? reqAddr : directAddr;
            directData <= directNext ? reqData : directData;
        end
    end

    // index object keeps the last written register number
    always_ff @(posedge clock)
    begin
        if (srst)
            index_reg <= 16'h0000;
        else if (isWr & kIndex)
            index_reg <= reqData; // R5 R19
    end

    // parameter entries: staged copy, active copy, pending and save marks
    genvar i;
    generate
        for (i = 0; i < PARAM_COUNT; i++)
        begin : g_entry
            logic [15:0] stage_reg;
            logic [15:0] active_reg;
            logic pending_reg;
            logic dirty_reg;
            logic mask_reg;
            wire hit = valueWrOk & (entrySel == AW'(i));
            wire promote = commitNow & pending_reg;
            wire directAct = hit & ~commitRequiredSelect;
            wire written = (state_reg == ipa_pkg::SV_WRITE) & nvmAck & (ptr_reg == AW'(i));
            assign activeVec[i] = active_reg;
            assign pendingVec[i] = pending_reg;
            assign saveMaskVec[i] = mask_reg;
            always_ff @(posedge clock)
            begin
                if (srst)
                begin
                    stage_reg <= 16'h0000;
                    active_reg <= 16'h0000;
                    pending_reg <= 1'b0;
                    dirty_reg <= 1'b0;
                    mask_reg <= 1'b0;
                end
                else
                begin
                    if (hit)
                        stage_reg <= reqData; // R6
                    if (directAct)
                        active_reg <= reqData; // R10
                    else if (promote)
                        active_reg <= stage_reg; // R7 R8
                    pending_reg <= (hit & commitRequiredSelect) | (pending_reg & ~commitNow); // R6 R10
                    dirty_reg <= directAct | ((promote | dirty_reg) & ~saveOk); // saved entries go clean
                    mask_reg <= (saveOk & (dirty_reg | pending_reg)) | (mask_reg & ~written); // R8
                end
            end
        end
    endgenerate

    // save walker next state
    always_comb
    begin
        case (state_reg)
            ipa_pkg::SV_IDLE:
                state_next = saveOk ? ipa_pkg::SV_SCAN : ipa_pkg::SV_IDLE;
            ipa_pkg::SV_SCAN:
                state_next = saveMaskVec[ptr_reg] ? ipa_pkg::SV_WRITE :
                    (ptr_reg == LAST) ? ipa_pkg::SV_IDLE : ipa_pkg::SV_SCAN;
            ipa_pkg::SV_WRITE:
                state_next = ~nvmAck ? ipa_pkg::SV_WRITE :
                    (ptr_reg == LAST) ? ipa_pkg::SV_IDLE : ipa_pkg::SV_SCAN;
            default:
                state_next = ipa_pkg::SV_IDLE;
        endcase
    end

    // save walker: one non-volatile write per marked entry
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_reg <= ipa_pkg::SV_IDLE;
            ptr_reg <= '0;
            nvmWrEn <= 1'b0;
            nvmAddr <= 16'h0000;
            nvmData <= 16'h0000;
            saving <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            saving <= (state_next != ipa_pkg::SV_IDLE);
            if (state_reg == ipa_pkg::SV_IDLE)
                ptr_reg <= '0;
            else if ((state_reg == ipa_pkg::SV_SCAN) & ~saveMaskVec[ptr_reg])
                ptr_reg <= ptr_reg + AW'(1);
            else if ((state_reg == ipa_pkg::SV_WRITE) & nvmAck)
                ptr_reg <= ptr_reg + AW'(1);
            if ((state_reg == ipa_pkg::SV_SCAN) & saveMaskVec[ptr_reg])
            begin
                nvmWrEn <= 1'b1; // R8
                nvmAddr <= 16'(ptr_reg);
                nvmData <= activeVec[ptr_reg];
            end
            else if (nvmAck)
                nvmWrEn <= 1'b0;
        end
    end

    // identity and test mode are caught once, right after power-up
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            booted_reg <= 1'b0;
            instanceId <= '0;
            reportedName <= '0;
            testArmed_reg <= 1'b0;
        end
        else if (~booted_reg)
        begin
            booted_reg <= 1'b1;
            instanceId <= {instanceIdParamHigh, instanceIdParamLow}; // R1 R2
            reportedName <= nameBoot; // R4
            testArmed_reg <= (inputSixFunctionSelect == `IPA_TEST_SELECT); // R17
        end
    end

    // network name writes are stored for the next power-up
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            storedName <= '0;
            nameStoreStrobe <= 1'b0;
        end
        else
        begin
            if (nameWrite)
                storedName <= nameData; // R3
            nameStoreStrobe <= nameWrite; // R4
        end
    end

    // pins into the clock domain
    ipa_pin_sync #(
        .WIDTH(2)
    ) u_sync (
        .clock(clock),
        .srst(srst),
        .pinIn({digitalInputSix, rxPin}),
        .pinOut(pinsSync)
    );

    // loopback self-test runs when armed and input six is jumpered
    wire testEnable = testArmed_reg & pinsSync[1]; // R17
    ipa_loop_test #(
        .BIT_CYCLES(TEST_BIT_CYCLES)
    ) u_test (
        .clock(clock),
        .srst(srst),
        .enable(testEnable),
        .rxLine(pinsSync[0]),
        .txLine(testTx),
        .testPass(testPass),
        .testFail(testFail)
    );

    // link and display drive
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            txLine <= 1'b1;
            displayPass <= 1'b0;
            displayCommError <= 1'b0;
        end
        else
        begin
            txLine <= testTx;
            displayPass <= testPass; // R18
            displayCommError <= testFail; // R18
        end
    end
endmodule : ipa_param_access

/* File: verification/ipa_param_props.sv */
/*
 checker of the parameter access ports: answers, error codes, holds.
 assumes a bind to ipa_param_access, ipa_pkg compiled first.
*/
`timescale 1ns/1ps
module ipa_param_props (
    // clock and reset
    input logic clock,
    input logic srst,
    // request port
    input logic reqValid,
    input logic reqWrite,
    input ipa_pkg::ipa_kind_e reqKind,
    input logic [15:0] reqData,
    // answers and side effects
    input logic rspValid,
    input logic [7:0] rspErr,
    input logic directWrite,
    input logic nameWrite,
    input logic nameStoreStrobe,
    input logic [21:0] instanceId,
    // store and display
    input logic nvmWrEn,
    input logic nvmAck,
    input logic saving,
    input logic displayPass,
    input logic displayCommError
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    // request decode
    wire logic wrReq = reqValid && reqWrite;
    wire logic valWr = wrReq && reqKind == ipa_pkg::KIND_VALUE;
    wire logic isCmd = reqKind == ipa_pkg::KIND_ACCEPT || reqKind == ipa_pkg::KIND_SAVE;
    wire logic cmdWr = wrReq && reqData[0] && isCmd;
    wire logic regRd = reqValid && !reqWrite && reqKind == ipa_pkg::KIND_REG;
    a_answer_next: assert property (reqValid |=> rspValid)
        else $error("no answer");
    a_quiet_idle: assert property (!reqValid |=> !rspValid && rspErr == 8'h0)
        else $error("stray answer");
    a_busy_write: assert property (valWr && saving |=> rspErr == 8'h3)
        else $error("value write not busy");
    a_busy_commit: assert property (cmdWr && saving |=> rspErr == 8'h3)
        else $error("commit not busy");
    a_reg_read: assert property (regRd |=> rspErr == 8'h2)
        else $error("register read allowed");
    a_direct_write: assert property (wrReq && reqKind == ipa_pkg::KIND_OTHER |=> directWrite)
        else $error("direct write lost");
    a_name_strobe: assert property (nameWrite |=> nameStoreStrobe)
        else $error("name not stored");
    a_nvm_hold: assert property (nvmWrEn && !nvmAck |=> nvmWrEn)
        else $error("store write dropped");
    a_save_bound: assert property ($rose(saving) |-> ##[1:1000] !saving)
        else $error("save hangs");
    a_id_stable: assert property (!$past(srst) && !$past(srst, 2) |-> $stable(instanceId))
        else $error("identifier changed");
    a_display_excl: assert property (!(displayPass && displayCommError))
        else $error("pass with fault");
    // main scenarios reached
    c_save: cover property ($rose(saving));
    c_busy: cover property (valWr && saving);
    c_pass: cover property ($rose(displayPass));
endmodule : ipa_param_props

bind ipa_param_access ipa_param_props u_ipa_param_props (
    .clock, .srst, .reqValid, .reqWrite, .reqKind, .reqData, .rspValid, .rspErr, .directWrite, .nameWrite,
    .nameStoreStrobe, .instanceId, .nvmWrEn, .nvmAck, .saving, .displayPass, .displayCommError
);

/* File: verification/ipa_nvm_model.sv */
/*
 store model: acks each write after ackDelay cycles and keeps the word.
 assumes nvmWrEn is held until the ack.
*/
`timescale 1ns/1ps
module ipa_nvm_model (
    // clock and reset
    input logic clock,
    input logic srst,
    // store port
    input logic nvmWrEn,
    input logic [15:0] nvmAddr,
    input logic [15:0] nvmData,
    input logic [3:0] ackDelay,
    output logic nvmAck
);
    logic [15:0] mem [0:63];
    logic [3:0] waitCnt;
    // write time, then one ack and the stored word
    always @(posedge clock)
    begin
        nvmAck <= 1'b0;
        if (srst)
            waitCnt <= 4'h0;
        else if (nvmWrEn && !nvmAck && waitCnt == ackDelay)
        begin
            nvmAck <= 1'b1;
            mem[nvmAddr[5:0]] <= nvmData;
            waitCnt <= 4'h0;
        end
        else if (nvmWrEn && !nvmAck)
            waitCnt <= waitCnt + 4'h1;
    end
endmodule : ipa_nvm_model

/* File: verification/testbench.sv */
/*
 testbench of the parameter access block.
 assumes the store model and checker are compiled with it.
*/
`timescale 1ns/1ps
module testbench;
    // stimulus
    logic clock, srst, reqValid, reqWrite, commitReq, autoTune, underVolt, nameWrite, digSix, breakLoop;
    ipa_pkg::ipa_kind_e reqKind;
    logic [15:0] reqAddr, reqData, instLo;
    logic [5:0] instHi;
    logic [7:0] selSix;
    logic [3:0] ackDelay;
    logic [159:0] nameData, nameBoot;
    // responses
    logic rspValid, directWrite, nameStoreStrobe, nvmWrEn, nvmAck, saving, txLine, displayPass, displayCommError;
    logic [15:0] rspData, directAddr, directData, nvmAddr, nvmData;
    logic [7:0] rspErr;
    logic [21:0] instanceId;
    logic [159:0] storedName, reportedName;
    wire logic rxPin;
    int n_fail = 0;
    int checks = 0;
    localparam ipa_pkg::ipa_kind_e kIdx = ipa_pkg::KIND_INDEX;
    localparam ipa_pkg::ipa_kind_e kVal = ipa_pkg::KIND_VALUE;
    localparam ipa_pkg::ipa_kind_e kAcc = ipa_pkg::KIND_ACCEPT;
    localparam ipa_pkg::ipa_kind_e kReg = ipa_pkg::KIND_REG;
    // loopback, or a stuck line for faults
    assign rxPin = breakLoop ? 1'b0 : txLine;
    // block under test and its store
    ipa_param_access #(.TEST_BIT_CYCLES(20)) u_ipa_param_access (
        .clock, .srst, .reqValid, .reqWrite, .reqKind, .reqAddr, .reqData, .rspValid, .rspData, .rspErr,
        .directWrite, .directAddr, .directData, .instanceIdParamHigh(instHi), .instanceIdParamLow(instLo),
        .commitRequiredSelect(commitReq), .inputSixFunctionSelect(selSix), .autoTuneActive(autoTune),
        .busUndervoltageFault(underVolt), .instanceId, .nameWrite, .nameData, .nameBoot, .storedName,
        .nameStoreStrobe, .reportedName, .nvmWrEn, .nvmAddr, .nvmData, .nvmAck, .saving, .rxPin,
        .digitalInputSix(digSix), .txLine, .displayPass, .displayCommError
    );
    ipa_nvm_model u_ipa_nvm_model (.clock, .srst, .nvmWrEn, .nvmAddr, .nvmData, .ackDelay, .nvmAck);
    // clock
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // verdict and end of run
    task automatic end_sim;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // compare one value
    task automatic chk(input logic [159:0] got, input logic [159:0] exp, input string msg);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : chk
    // reset held 20 cycles, then two edges for the identity
    task automatic do_reset;
        srst = 1'b1;
        repeat (20) @(negedge clock);
        srst = 1'b0;
        repeat (2) @(negedge clock);
    endtask : do_reset
    // one request; the answer stands in the cycle after it is taken
    task automatic req(input logic wr, input ipa_pkg::ipa_kind_e k, input logic [15:0] a, input logic [15:0] d,
                       input logic [7:0] eErr, input logic [15:0] eData);
        @(negedge clock);
        reqValid = 1'b1;
        reqWrite = wr;
        reqKind = k;
        reqAddr = a;
        reqData = d;
        @(negedge clock);
        reqValid = 1'b0;
        chk(rspValid, 1'b1, "answer");
        chk(rspErr, eErr, "error");
        if (!wr)
            chk(rspData, eData, "data");
    endtask : req
    // object write and read shorthands
    task automatic w(input ipa_pkg::ipa_kind_e k, input logic [15:0] d, input logic [7:0] eErr);
        req(1'b1, k, 16'h0, d, eErr, 16'h0);
    endtask : w
    task automatic r(input ipa_pkg::ipa_kind_e k, input logic [7:0] eErr, input logic [15:0] eData);
        req(1'b0, k, 16'h0, 16'h0, eErr, eData);
    endtask : r
    // identity caught at power-up only
    task automatic t_ident;
        chk(instanceId, 22'h3FFFFF, "id");
        instHi = 6'h1;
        instLo = 16'h2;
        nameData = "network_written_name";
        nameWrite = 1'b1;
        @(negedge clock);
        nameWrite = 1'b0;
        chk(storedName, nameData, "stored name");
        chk(reportedName, nameBoot, "old name");
        chk(instanceId, 22'h3FFFFF, "id kept");
        nameBoot = nameData;
        do_reset;
        chk(instanceId, 22'h010002, "new id");
        chk(reportedName, nameData, "new name");
    endtask : t_ident
    // staging, accept by object and by register, write-only registers, direct objects
    task automatic t_commit;
        w(kIdx, 16'h5, 8'h0);
        r(kIdx, 8'h0, 16'h5);
        w(kVal, 16'h11, 8'h0);
        w(kAcc, 16'h1, 8'h0);
        r(kVal, 8'h0, 16'h11);
        w(kVal, 16'h7, 8'h0);
        r(kVal, 8'h0, 16'h11);
        req(1'b1, kReg, 16'h910, 16'h0, 8'h0, 16'h0);
        r(kVal, 8'h0, 16'h7);
        req(1'b0, kReg, 16'h910, 16'h0, 8'h2, 16'h0);
        req(1'b0, kReg, 16'h900, 16'h0, 8'h2, 16'h0);
        req(1'b1, kReg, 16'h910, 16'h1, 8'h2, 16'h0);
        r(kAcc, 8'h0, 16'h0);
        r(ipa_pkg::KIND_SAVE, 8'h0, 16'h0);
        commitReq = 1'b0;
        w(kVal, 16'h9, 8'h0);
        r(kVal, 8'h0, 16'h9);
        req(1'b1, ipa_pkg::KIND_OTHER, 16'h42, 16'h1234, 8'h0, 16'h0);
        chk(directWrite, 1'b1, "direct strobe");
        chk({directAddr, directData}, 32'h00421234, "direct word");
    endtask : t_commit
    // refusals and their order
    task automatic t_errors;
        w(kIdx, 16'h40, 8'h0);
        r(kVal, 8'h1B, 16'h0);
        w(kVal, 16'h1, 8'h28);
        w(kIdx, 16'h5, 8'h0);
        w(kVal, 16'h8000, 8'h25);
        w(kVal, 16'h7FFF, 8'h0);
        autoTune = 1'b1;
        w(kVal, 16'h1, 8'h28);
        autoTune = 1'b0;
        underVolt = 1'b1;
        w(kVal, 16'h8000, 8'h28);
        underVolt = 1'b0;
        r(kVal, 8'h0, 16'h7FFF);
    endtask : t_errors
    // save by object then register, store fast then slow
    task automatic t_save;
        logic [15:0] v;
        commitReq = 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            v = i ? 16'h121 : 16'h120;
            ackDelay = i ? 4'h6 : 4'h0;
            w(kIdx, 16'h3, 8'h0);
            w(kVal, v, 8'h0);
            if (i)
                req(1'b1, kReg, 16'h900, 16'h0, 8'h0, 16'h0);
            else
                w(ipa_pkg::KIND_SAVE, 16'h1, 8'h0);
            w(kVal, 16'h55, 8'h3);
            w(kAcc, 16'h1, 8'h3);
            for (int j = 0; j < 2000 && saving !== 1'b0; j++)
                @(negedge clock);
            chk(saving, 1'b0, "save done");
            chk(u_ipa_nvm_model.mem[3], v, "stored word");
            r(kVal, 8'h0, v);
        end
    endtask : t_save
    // loopback self-test armed only by the select at boot
    task automatic t_loop;
        digSix = 1'b1;
        repeat (300) @(negedge clock);
        chk(displayPass, 1'b0, "not armed");
        selSix = 8'h43;
        do_reset;
        for (int i = 0; i < 400 && displayPass !== 1'b1; i++)
            @(negedge clock);
        chk(displayPass, 1'b1, "test pass");
        breakLoop = 1'b1;
        for (int i = 0; i < 400 && displayCommError !== 1'b1; i++)
            @(negedge clock);
        chk(displayCommError, 1'b1, "fault shown");
        breakLoop = 1'b0;
        repeat (100) @(negedge clock);
        chk(displayPass, 1'b0, "fault sticky");
    endtask : t_loop
    // main sequence
    initial
    begin
        srst = 1'b1;
        reqValid = 1'b0;
        reqWrite = 1'b0;
        reqKind = kIdx;
        reqAddr = 16'h0000;
        reqData = 16'h0000;
        instHi = 6'h3F;
        instLo = 16'hFFFF;
        commitReq = 1'b1;
        selSix = 8'h00;
        autoTune = 1'b0;
        underVolt = 1'b0;
        nameWrite = 1'b0;
        nameData = '0;
        nameBoot = "boot_name";
        digSix = 1'b0;
        breakLoop = 1'b0;
        ackDelay = 4'h0;
        do_reset;
        t_ident;
        t_commit;
        t_errors;
        t_save;
        t_loop;
        end_sim;
    end
    // cut a hang short
    initial
    begin
        #1000000;
        n_fail++;
        end_sim;
    end
endmodule : testbench
